// ===== common/acs_pkg.sv
// Shared constants, types and helpers of the conversion sequencer
package acs_pkg;

	// ************************************************************
	// Conversion geometry and timing
	// ************************************************************
	localparam int unsigned RES_BITS = 10;
	localparam int unsigned TAD_PER_CONV = 12;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned INSTR_CYCLE_NS = 400;
	localparam int unsigned CLKS_PER_INSTR = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RC_DIV_DEFAULT = 16;
	localparam logic [3:0] TAD_LAST = 4'(TAD_PER_CONV - 1);
	localparam logic [3:0] TAD_FIRST_BIT = 4'h1;
	localparam logic [3:0] TAD_LAST_BIT = 4'(RES_BITS);

	// ************************************************************
	// Field codes
	// ************************************************************
	localparam logic [2:0] CLKSEL_RC_BITS = 3'h3;
	localparam logic [4:0] TRIG_NONE = 5'h00;
	localparam int unsigned TRIG_SRC_COUNT = 17;
	localparam int unsigned JUSTIFY_PAD = 6;

	// ************************************************************
	// Reset and conversion start values
	// ************************************************************
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [9:0] SAR_START = 10'h200;
	localparam logic [9:0] SAR_RST = 10'h000;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} acs_result_s;

	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_DELAY,
		ACS_CONV
	} acs_state_e;

	// Bits not yet decided copy the last decided bit
	function automatic logic [9:0] acs_fill(input logic [9:0] sar, input logic [9:0] mask,
		input logic last_bit);
		acs_fill = (sar & mask) | (~mask & {RES_BITS{last_bit}});
	endfunction : acs_fill

	// Right justified when sel is 1, left justified when 0
	function automatic acs_result_s acs_format(input logic [9:0] res, input logic sel);
		acs_result_s r;
		if (sel) begin
			r.high = {{JUSTIFY_PAD{1'b0}}, res[9:8]};
			r.low = res[7:0];
		end else begin
			r.high = res[9:2];
			r.low = {res[1:0], {JUSTIFY_PAD{1'b0}}};
		end
		acs_format = r;
	endfunction : acs_format

endpackage : acs_pkg

// ===== verilog/acs_tad_divider.sv
// Conversion clock period tick generator
`timescale 1ns/10ps
module acs_tad_divider import acs_pkg::*; #(
	parameter int unsigned RC_DIV = RC_DIV_DEFAULT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic [2:0] clk_sel_i,
	input wire logic restart_i,
	// Tick
	output logic tick_o
);

	// ************************************************************
	// Divisor decode
	// ************************************************************
	function automatic logic [7:0] acs_divisor(input logic [2:0] sel);
		unique case (sel)
			3'h0: acs_divisor = 8'h02;
			3'h4: acs_divisor = 8'h04;
			3'h1: acs_divisor = 8'h08;
			3'h5: acs_divisor = 8'h10;
			3'h2: acs_divisor = 8'h20;
			3'h6: acs_divisor = 8'h40;
			default: acs_divisor = 8'(RC_DIV);
		endcase
	endfunction : acs_divisor

	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic tick_reg;
	wire logic [7:0] div_w = acs_divisor(clk_sel_i);
	wire logic wrap_w = (cnt_reg >= div_w - 8'h01);

	// Restart aligns the first period to the conversion start
	assign cnt_next = (restart_i || wrap_w) ? 8'h00 : cnt_reg + 8'h01;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= wrap_w && !restart_i;
		end
	end

	assign tick_o = tick_reg;

endmodule : acs_tad_divider

// ===== verilog/acs_trigger_edge.sv
// Auto-trigger source select, synchroniser and rising edge detector
`timescale 1ns/10ps
module acs_trigger_edge import acs_pkg::*; #(
	parameter int unsigned SRC_COUNT = TRIG_SRC_COUNT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Selection
	input wire logic [4:0] sel_i,
	input wire logic [SRC_COUNT-1:0] src_i,
	input wire logic arm_i,
	// Start pulse
	output logic pulse_o
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;
	logic pulse_reg;
	wire logic sel_valid_w = (sel_i != TRIG_NONE) && (int'(sel_i) <= SRC_COUNT);
	wire logic [4:0] idx_w = sel_i - 5'h01;
	wire logic raw_w = sel_valid_w ? src_i[idx_w] : 1'b0;
	wire logic rise_w = sync_reg && !prev_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else begin
			meta_reg <= raw_w;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			pulse_reg <= rise_w && arm_i;
		end
	end

	assign pulse_o = pulse_reg;

endmodule : acs_trigger_edge

// ===== verilog/acs_conv_sequencer.sv
// Successive approximation converter sequencer, top level
`timescale 1ns/10ps
module acs_conv_sequencer import acs_pkg::*; #(
	parameter int unsigned RC_DIV = RC_DIV_DEFAULT,
	parameter int unsigned SRC_COUNT = TRIG_SRC_COUNT
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Control bits from software
	input wire logic converter_enable_i,
	input wire logic go_wr_i,
	input wire logic go_wr_data_i,
	input wire logic [2:0] clk_sel_i,
	input wire logic result_justify_sel_i,
	input wire logic [4:0] auto_trigger_select_i,
	input wire logic conv_irq_enable_i,
	input wire logic flag_clr_i,
	// Power state
	input wire logic sleep_i,
	// Trigger sources
	input wire logic [SRC_COUNT-1:0] trig_src_i,
	// Analog core
	input wire logic cmp_i,
	output logic analog_power_o,
	output logic sample_o,
	output logic [9:0] dac_code_o,
	// Status to software
	output logic go_o,
	output logic conv_done_flag_o,
	output acs_result_s result_o,
	output logic wake_o
);

	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_meta_reg;
	logic rst_sync_reg;
	wire logic rst_n = rst_sync_reg;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ************************************************************
	// State
	// ************************************************************
	acs_state_e state_reg;
	acs_state_e state_next;
	logic go_reg;
	logic go_next;
	logic flag_reg;
	logic flag_next;
	logic pd_reg;
	logic pd_next;
	logic wake_reg;
	logic [3:0] tad_cnt_reg;
	logic [3:0] tad_cnt_next;
	logic [3:0] dly_cnt_reg;
	logic [3:0] dly_cnt_next;
	logic [9:0] sar_reg;
	logic [9:0] sar_next;
	logic [9:0] mask_reg;
	logic [9:0] mask_next;
	logic last_bit_reg;
	logic last_bit_next;
	acs_result_s result_reg;
	acs_result_s result_next;
	logic tad_tick;
	logic trig_pulse;

	// ************************************************************
	// Decode
	// ************************************************************
	wire logic rc_sel_w = ((clk_sel_i & CLKSEL_RC_BITS) == CLKSEL_RC_BITS);
	wire logic active_w = converter_enable_i && !pd_reg;
	wire logic sw_set_w = go_wr_i && go_wr_data_i;
	wire logic sw_clr_w = go_wr_i && !go_wr_data_i;
	wire logic start_w = active_w && !go_reg && (sw_set_w || trig_pulse);
	wire logic busy_w = (state_reg != ACS_IDLE);
	wire logic in_conv_w = (state_reg == ACS_CONV);
	wire logic enter_conv_w = (state_reg == ACS_DELAY) ?
		(dly_cnt_reg == 4'(CLKS_PER_INSTR - 1)) : (start_w && !rc_sel_w);
	// Sleep with a system-derived clock kills the conversion outright
	wire logic sleep_abort_w = busy_w && sleep_i && !rc_sel_w;
	wire logic off_abort_w = busy_w && !converter_enable_i;
	wire logic hard_abort_w = sleep_abort_w || off_abort_w;
	wire logic sw_abort_w = busy_w && sw_clr_w && !hard_abort_w;
	wire logic complete_w = in_conv_w && tad_tick && (tad_cnt_reg == TAD_LAST) &&
		!hard_abort_w;
	wire logic decide_w = in_conv_w && tad_tick && (tad_cnt_reg >= TAD_FIRST_BIT) &&
		(tad_cnt_reg <= TAD_LAST_BIT);
	wire logic [3:0] bit_idx_w = 4'(RES_BITS) - tad_cnt_reg;
	wire logic [9:0] one_hot_w = decide_w ? (10'h001 << bit_idx_w) : 10'h000;
	wire logic [9:0] below_w = one_hot_w >> 1;
	wire logic [9:0] fill_w = acs_fill(sar_reg, mask_reg, last_bit_reg);
	wire logic load_w = complete_w || sw_abort_w;

	// ************************************************************
	// Sub-blocks
	// ************************************************************
	acs_tad_divider #(
		.RC_DIV(RC_DIV)
	) u_tad_divider (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.clk_sel_i(clk_sel_i),
		.restart_i(enter_conv_w),
		.tick_o(tad_tick)
	);

	acs_trigger_edge #(
		.SRC_COUNT(SRC_COUNT)
	) u_trigger_edge (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.sel_i(auto_trigger_select_i),
		.src_i(trig_src_i),
		.arm_i(!sleep_i),
		.pulse_o(trig_pulse)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ACS_IDLE: begin
				if (start_w) begin
					state_next = rc_sel_w ? ACS_DELAY : ACS_CONV;
				end
			end
			ACS_DELAY: begin
				if (hard_abort_w || sw_abort_w) begin
					state_next = ACS_IDLE;
				end else if (enter_conv_w) begin
					state_next = ACS_CONV;
				end
			end
			ACS_CONV: begin
				if (hard_abort_w || sw_abort_w || complete_w) begin
					state_next = ACS_IDLE;
				end
			end
		endcase
	end

	// Extra instruction-cycle wait only used on the RC clock
	assign dly_cnt_next = (state_reg == ACS_DELAY) ? dly_cnt_reg + 4'h1 : 4'h0;
	assign tad_cnt_next = enter_conv_w ? 4'h0 :
		(in_conv_w && tad_tick) ? tad_cnt_reg + 4'h1 : tad_cnt_reg;

	// Go reads one for the whole cycle, hardware drops it at the end
	assign go_next = start_w ? 1'b1 :
		(complete_w || hard_abort_w || sw_abort_w) ? 1'b0 : go_reg;

	// ************************************************************
	// Successive approximation
	// ************************************************************
	assign sar_next = enter_conv_w ? SAR_START :
		(sar_reg & ~one_hot_w) | (cmp_i ? one_hot_w : 10'h000) | below_w;
	assign mask_next = enter_conv_w ? 10'h000 : (mask_reg | one_hot_w);
	assign last_bit_next = enter_conv_w ? 1'b0 : (decide_w ? cmp_i : last_bit_reg);

	// ************************************************************
	// Result and flags
	// ************************************************************
	// Justification is applied once at load; later select changes do not reformat
	assign result_next = load_w ? acs_format(fill_w, result_justify_sel_i) : result_reg;
	// A completion in the clear cycle keeps the flag set
	assign flag_next = complete_w || (flag_reg && !flag_clr_i);
	assign pd_next = (!converter_enable_i || !sleep_i) ? 1'b0 :
		((sleep_i && !rc_sel_w) || (complete_w && !conv_irq_enable_i)) ? 1'b1 :
		pd_reg;

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ACS_IDLE;
			go_reg <= 1'b0;
			flag_reg <= 1'b0;
			pd_reg <= 1'b0;
			wake_reg <= 1'b0;
			tad_cnt_reg <= 4'h0;
			dly_cnt_reg <= 4'h0;
			sar_reg <= SAR_RST;
			mask_reg <= SAR_RST;
			last_bit_reg <= 1'b0;
			result_reg <= '{high: RESULT_RST, low: RESULT_RST};
		end else begin
			state_reg <= state_next;
			go_reg <= go_next;
			flag_reg <= flag_next;
			pd_reg <= pd_next;
			wake_reg <= complete_w && sleep_i && conv_irq_enable_i;
			tad_cnt_reg <= tad_cnt_next;
			dly_cnt_reg <= dly_cnt_next;
			sar_reg <= sar_next;
			mask_reg <= mask_next;
			last_bit_reg <= last_bit_next;
			result_reg <= result_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Power follows enable unless reset or a Sleep power-down is holding it off
	assign analog_power_o = converter_enable_i && !pd_reg && rst_n;
	assign sample_o = analog_power_o && !in_conv_w;
	assign dac_code_o = sar_reg;
	assign go_o = go_reg;
	assign conv_done_flag_o = flag_reg;
	assign result_o = result_reg;
	assign wake_o = wake_reg;

endmodule : acs_conv_sequencer

// ===== sim/acs_conv_sequencer_chk.sv
// Port-level assertion checker for the conversion sequencer
`timescale 1ns/10ps
module acs_conv_chk import acs_pkg::*; #(
	parameter int unsigned RC_DIV = RC_DIV_DEFAULT,
	parameter int unsigned SRC_COUNT = TRIG_SRC_COUNT
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic converter_enable_i,
	input wire logic go_wr_i,
	input wire logic go_wr_data_i,
	input wire logic [2:0] clk_sel_i,
	input wire logic conv_irq_enable_i,
	input wire logic flag_clr_i,
	input wire logic sleep_i,
	// Status
	input wire logic analog_power_o,
	input wire logic go_o,
	input wire logic conv_done_flag_o,
	input wire acs_result_s result_o,
	input wire logic wake_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] go_cnt_reg;
	// Busy length counter, only judged with the divide-by-two clock
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) go_cnt_reg <= 8'h00;
		else go_cnt_reg <= go_o ? go_cnt_reg + 8'h01 : 8'h00;
	end
	a_flag_sticky: assert property (conv_done_flag_o && !flag_clr_i |=> conv_done_flag_o)
		else $error("completion flag dropped without a clear");
	a_done_clears_go: assert property ($rose(conv_done_flag_o) |-> $fell(go_o))
		else $error("flag set without go falling");
	a_go_start: assert property (go_wr_i && go_wr_data_i && converter_enable_i && analog_power_o
		&& !go_o && !sleep_i |=> go_o)
		else $error("go write did not start a conversion");
	a_power_enable: assert property (!converter_enable_i |-> !analog_power_o)
		else $error("converter powered while disabled");
	a_abort_go: assert property (go_o && go_wr_i && !go_wr_data_i |=> !go_o)
		else $error("go stayed set after abort");
	a_conv_length: assert property ($rose(conv_done_flag_o) && clk_sel_i == 3'h0
		|-> go_cnt_reg inside {[22:26]})
		else $error("conversion length wrong");
	a_wake_cause: assert property ($rose(conv_done_flag_o) && sleep_i && conv_irq_enable_i
		|-> ##[0:1] wake_o)
		else $error("no wake after completion in sleep");
	a_wake_pulse: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
	a_sleep_abort: assert property (sleep_i && go_o && clk_sel_i[1:0] != 2'b11 |=> !go_o)
		else $error("sleep did not abort conversion");
	a_sleep_power: assert property (sleep_i && go_o && clk_sel_i[1:0] != 2'b11 ##1 sleep_i
		|-> !analog_power_o)
		else $error("converter powered in sleep");
	a_result_hold: assert property ($changed(result_o) |-> $fell(go_o))
		else $error("result changed outside completion or abort");
	c_done: cover property ($rose(conv_done_flag_o));
	c_abort: cover property (go_o && go_wr_i && !go_wr_data_i);
	c_wake: cover property (wake_o);
endmodule : acs_conv_chk

bind acs_conv_sequencer acs_conv_chk #(.RC_DIV(RC_DIV), .SRC_COUNT(SRC_COUNT)) u_chk (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .converter_enable_i(converter_enable_i),
	.go_wr_i(go_wr_i), .go_wr_data_i(go_wr_data_i), .clk_sel_i(clk_sel_i),
	.conv_irq_enable_i(conv_irq_enable_i), .flag_clr_i(flag_clr_i), .sleep_i(sleep_i),
	.analog_power_o(analog_power_o), .go_o(go_o), .conv_done_flag_o(conv_done_flag_o),
	.result_o(result_o), .wake_o(wake_o));

// ===== sim/acs_core_model.sv
// Behavioural sample-and-hold and comparator of the analog core
`timescale 1ns/10ps
module acs_core_model (
	// Clock
	input wire logic clk_i,
	// Analog side
	input wire logic [9:0] level_i,
	input wire logic power_i,
	input wire logic sample_i,
	input wire logic [9:0] dac_code_i,
	// Comparator
	output logic cmp_o
);
	logic [9:0] held_reg = 10'h000;
	logic alt_reg = 1'b0;
	// Unpowered comparator is meaningless, so it toggles every cycle
	always_ff @(posedge clk_i) begin
		alt_reg <= ~alt_reg;
		if (sample_i) held_reg <= level_i;
	end
	assign cmp_o = power_i ? (held_reg >= dac_code_i) : alt_reg;
endmodule : acs_core_model

// ===== sim/acs_conv_sequencer_bench.sv
// Self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
`define CHK_EQ(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module acs_conv_sequencer_bench import acs_pkg::*;;
	logic ref_clk_i, rst_n_i, converter_enable_i, go_wr_i, go_wr_data_i, result_justify_sel_i;
	logic conv_irq_enable_i, flag_clr_i, sleep_i, cmp, power, sample, go_o, flag, wake, go_q;
	logic [2:0] clk_sel_i;
	logic [4:0] auto_trigger_select_i;
	logic [16:0] trig_src_i;
	logic [9:0] dac, ain;
	logic [15:0] exp_v;
	acs_result_s result_o;
	logic [15:0] exp_q[$];
	int errors, num_checks, wakes, seed;
	acs_conv_sequencer #(.RC_DIV(2)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.converter_enable_i(converter_enable_i), .go_wr_i(go_wr_i), .go_wr_data_i(go_wr_data_i),
		.clk_sel_i(clk_sel_i), .result_justify_sel_i(result_justify_sel_i),
		.auto_trigger_select_i(auto_trigger_select_i), .conv_irq_enable_i(conv_irq_enable_i),
		.flag_clr_i(flag_clr_i), .sleep_i(sleep_i), .trig_src_i(trig_src_i), .cmp_i(cmp),
		.analog_power_o(power), .sample_o(sample), .dac_code_o(dac), .go_o(go_o),
		.conv_done_flag_o(flag), .result_o(result_o), .wake_o(wake));
	acs_core_model u_core (.clk_i(ref_clk_i), .level_i(ain), .power_i(power), .sample_i(sample),
		.dac_code_i(dac), .cmp_o(cmp));
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : step
	task automatic wait_go(input logic v);
		int k;
		k = 0;
		while (go_o !== v && k < 300) begin
			step(1);
			k++;
		end
		if (k == 300) begin
			errors++;
			test_done();
		end
	endtask : wait_go
	task automatic go_write(input logic d);
		go_wr_data_i = d;
		go_wr_i = 1'b1;
		step(1);
		go_wr_i = 1'b0;
		go_wr_data_i = 1'b1;
	endtask : go_write
	task automatic clear_flag();
		flag_clr_i = 1'b1;
		step(1);
		flag_clr_i = 1'b0;
	endtask : clear_flag
	// Software start when code is zero, else a pulse on the chosen source
	task automatic conv(input logic [9:0] v, input logic [4:0] code);
		ain = v;
		result_justify_sel_i = v[0];
		exp_q.push_back(v[0] ? {6'h00, v} : {v, 6'h00});
		auto_trigger_select_i = code;
		step(2);
		if (code == 5'h00) go_write(1'b1);
		else begin
			trig_src_i[code - 5'h01] = 1'b1;
			step(1);
			trig_src_i = 17'h0_0000;
		end
		wait_go(1'b1);
		wait_go(1'b0);
		step(1);
		`CHK_EQ("done flag", 1'b1, flag)
		clear_flag();
		`CHK_EQ("flag clear", 1'b0, flag)
	endtask : conv
	task automatic rc_sleep(input logic irq);
		ain = 10'($random(seed));
		result_justify_sel_i = 1'b1;
		exp_q.push_back({6'h00, ain});
		conv_irq_enable_i = irq;
		wakes = 0;
		step(2);
		go_write(1'b1);
		step(2);
		sleep_i = 1'b1;
		wait_go(1'b0);
		step(2);
		`CHK_EQ("wake count", 32'(irq), wakes)
		`CHK_EQ("rc power", irq, power)
		sleep_i = 1'b0;
		clear_flag();
	endtask : rc_sleep
	// The scoreboard takes the oldest expected result at each completion
	always @(negedge ref_clk_i) begin
		if (go_q === 1'b1 && go_o === 1'b0 && flag === 1'b1 && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK_EQ("result", exp_v, result_o)
		end
		if (wake === 1'b1) wakes++;
		go_q = go_o;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		seed = 50;
		{rst_n_i, converter_enable_i, go_wr_i, result_justify_sel_i, conv_irq_enable_i} = 5'h00;
		{flag_clr_i, sleep_i, clk_sel_i, auto_trigger_select_i} = 10'h000;
		go_wr_data_i = 1'b1;
		trig_src_i = 17'h0_0000;
		ain = 10'h000;
		step(3);
		rst_n_i = 1'b1;
		step(3);
		`CHK_EQ("reset go", 1'b0, go_o)
		`CHK_EQ("reset result", 16'h0000, result_o)
		`CHK_EQ("reset power", 1'b0, power)
		`CHK_EQ("reset sample", 1'b0, sample)
		converter_enable_i = 1'b1;
		step(4);
		conv(10'h000, 5'h00);
		conv(10'h3ff, 5'h00);
		repeat (4) conv(10'($random(seed)), 5'h00);
		$display("software conversions done");
		for (int c = 1; c < 18; c++) conv(10'($random(seed)), 5'(c));
		auto_trigger_select_i = 5'h00;
		trig_src_i = 17'h1_ffff;
		step(8);
		`CHK_EQ("no trigger", 1'b0, go_o)
		trig_src_i = 17'h0_0000;
		$display("trigger conversions done");
		ain = 10'h3ff;
		result_justify_sel_i = 1'b1;
		step(2);
		go_write(1'b1);
		`CHK_EQ("start code", 10'h200, dac)
		`CHK_EQ("start sample", 1'b0, sample)
		step(9);
		go_write(1'b0);
		`CHK_EQ("abort go", 1'b0, go_o)
		`CHK_EQ("abort result", 16'h03ff, result_o)
		`CHK_EQ("abort flag", 1'b0, flag)
		go_write(1'b1);
		step(6);
		sleep_i = 1'b1;
		step(1);
		`CHK_EQ("sleep go", 1'b0, go_o)
		`CHK_EQ("sleep power", 1'b0, power)
		auto_trigger_select_i = 5'h01;
		trig_src_i = 17'h0_0001;
		step(8);
		`CHK_EQ("sleep trigger", 1'b0, go_o)
		trig_src_i = 17'h0_0000;
		auto_trigger_select_i = 5'h00;
		sleep_i = 1'b0;
		step(2);
		$display("abort tests done");
		clk_sel_i = CLKSEL_RC_BITS;
		rc_sleep(1'b1);
		rc_sleep(1'b0);
		$display("sleep tests done");
		test_done();
	end
endmodule : acs_conv_sequencer_bench
